// *** tmss_defs.svh ***
`ifndef TMSS_DEFS_SVH
`define TMSS_DEFS_SVH

// Matrix geometry
`define TMSS_NUM_X 8
`define TMSS_NUM_Y 3
`define TMSS_NUM_KEYS 24

// Timing
`define TMSS_CLK_MHZ 125
`define TMSS_DWELL_NS 375
`define TMSS_DWELL_CYC ((`TMSS_DWELL_NS * `TMSS_CLK_MHZ) / 1000)
`define TMSS_SELFTEST_US 5000
`define TMSS_SELFTEST_CYC (`TMSS_SELFTEST_US * `TMSS_CLK_MHZ)
`define TMSS_PULSE_GAP_CYC 16
`define TMSS_CONV_CYC 32

`endif

// *** tmss_pkg.sv ***
package tmss_pkg;
   typedef enum logic [2:0] {
      TMSS_IDLE  = 3'b000,
      TMSS_FIND  = 3'b001,
      TMSS_DWELL = 3'b010,
      TMSS_GAP   = 3'b011,
      TMSS_CONV  = 3'b100,
      TMSS_TEST  = 3'b101
   } tmss_state_t;
endpackage

// *** tmss_count_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tmss_defs.svh"
module tmss_count_timer #(
   parameter int W = 20
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Control
   input wire logic i_load,
   input wire logic [W-1:0] i_count,
   // Status
   output logic o_done
);
   logic [W-1:0] cnt_reg;
   logic busy_reg;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_load) begin
            cnt_reg <= i_count;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            if (cnt_reg <= 1) begin
               busy_reg <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - 1'b1;
            end
         end
      end
   end
endmodule // tmss_count_timer
`default_nettype wire

// *** tmss_scan_seq.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tmss_defs.svh"
module tmss_scan_seq #(
   parameter int NUM_X = `TMSS_NUM_X,
   parameter int NUM_Y = `TMSS_NUM_Y,
   parameter int SELFTEST_CYC = `TMSS_SELFTEST_CYC,
   parameter int CONV_CYC = `TMSS_CONV_CYC,
   parameter int GAP_CYC = `TMSS_PULSE_GAP_CYC,
   parameter int SIG_W = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Setups, per-key ones with key k in slice k, then shared signal limit and calibrate
   input wire logic [NUM_X*NUM_Y*8-1:0] i_burst_pulse_count,
   input wire logic [NUM_X*NUM_Y*4-1:0] i_normal_detect_integrator_limit,
   input wire logic [7:0] i_lower_signal_limit,
   input wire logic i_calibrate,
   // Analog front end
   input wire logic [SIG_W-1:0] i_adc_value,
   // Matrix drive
   output logic [NUM_X-1:0] o_x_drive,
   output logic [NUM_Y-1:0] o_y_capture,
   output logic o_convert,
   // Per-key report
   output logic o_report_valid,
   output logic [4:0] o_report_key,
   output logic [SIG_W-1:0] o_report_signal,
   output logic [SIG_W-1:0] o_report_reference,
   output logic o_report_low_signal,
   output logic o_report_calibrating,
   output logic o_report_cal_failed,
   output logic o_report_detect,
   // Scan status
   output logic o_scan_done,
   output logic o_self_test
);
   import tmss_pkg::*;

   localparam int NK = NUM_X * NUM_Y;
   localparam int DWELL_CYC = (`TMSS_DWELL_CYC < 1) ? 1 : `TMSS_DWELL_CYC;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic logic key_enabled(input logic [NK*4-1:0] lim, input logic [4:0] k);
      key_enabled = (lim[k*4 +: 4] != 4'h0);
   endfunction

   function automatic logic [7:0] key_burst(input logic [NK*8-1:0] bl, input logic [4:0] k);
      key_burst = bl[k*8 +: 8];
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   tmss_state_t state_reg, state_next;
   logic [4:0] key_reg;
   logic [7:0] pulse_reg;
   logic cal_pend_reg;
   logic cal_scan_reg;
   logic tmr_load;
   logic [31:0] tmr_count;
   logic tmr_done;
   logic [SIG_W-1:0] adc_s1_reg, adc_s2_reg;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   wire logic cur_en = key_enabled(i_normal_detect_integrator_limit, key_reg);
   wire logic last_key = (key_reg == 5'(NK - 1));
   wire logic [2:0] key_x = 3'(key_reg % NUM_X);
   wire logic [1:0] key_y = 2'(key_reg / NUM_X);
   wire logic [7:0] cur_bl = key_burst(i_burst_pulse_count, key_reg);
   wire logic burst_end = (pulse_reg + 8'h01 >= cur_bl);
   wire logic cur_live = cur_en && (cur_bl != 8'h00);
   wire logic test_end = (state_reg == TMSS_TEST) && tmr_done;
   wire logic key_step = ((state_reg == TMSS_FIND) && !cur_live && !last_key) ||
      ((state_reg == TMSS_CONV) && tmr_done && !last_key);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      tmr_load = 1'b0;
      tmr_count = 32'(GAP_CYC);
      case (state_reg)
         TMSS_IDLE: begin
            state_next = TMSS_FIND;
         end
         TMSS_FIND: begin
            if (cur_live) begin
               state_next = TMSS_DWELL;
               tmr_load = 1'b1;
               tmr_count = 32'(DWELL_CYC);
            end else if (last_key) begin
               state_next = TMSS_TEST;
               tmr_load = 1'b1;
               tmr_count = 32'(SELFTEST_CYC);
            end
         end
         TMSS_DWELL: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (burst_end) begin
                  state_next = TMSS_CONV;
                  tmr_count = 32'(CONV_CYC);
               end else begin
                  state_next = TMSS_GAP;
                  tmr_count = 32'(GAP_CYC);
               end
            end
         end
         TMSS_GAP: begin
            if (tmr_done) begin
               state_next = TMSS_DWELL;
               tmr_load = 1'b1;
               tmr_count = 32'(DWELL_CYC);
            end
         end
         TMSS_CONV: begin
            if (tmr_done) begin
               if (last_key) begin
                  state_next = TMSS_TEST;
                  tmr_load = 1'b1;
                  tmr_count = 32'(SELFTEST_CYC);
               end else begin
                  state_next = TMSS_FIND;
               end
            end
         end
         TMSS_TEST: begin
            if (tmr_done) begin
               state_next = TMSS_FIND;
            end
         end
         default: begin
            state_next = TMSS_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Timer
   // ------------------------------------------------------------
   // Timing from system clock only
   tmss_count_timer #(
      .W(32)
   ) tmss_count_timer_inst (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_load(tmr_load),
      .i_count(tmr_count),
      .o_done(tmr_done)
   );

   // ------------------------------------------------------------
   // Sequencer registers
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         adc_s1_reg <= '0;
         adc_s2_reg <= '0;
      end else begin
         adc_s1_reg <= i_adc_value;
         adc_s2_reg <= adc_s1_reg;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= TMSS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         key_reg <= 5'h00;
      end else if (state_reg == TMSS_TEST) begin
         key_reg <= 5'h00;
      end else if (key_step) begin
         key_reg <= key_reg + 5'h01;
      end
   end

   // Pulse count within one burst
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pulse_reg <= 8'h00;
      end else if (state_reg == TMSS_FIND) begin
         pulse_reg <= 8'h00;
      end else if (state_reg == TMSS_DWELL && tmr_done) begin
         pulse_reg <= pulse_reg + 8'h01;
      end
   end

   // Calibrate marker: clear wins over set at scan end, a request then going straight to cal_scan_reg
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cal_pend_reg <= 1'b1;
         cal_scan_reg <= 1'b0;
      end else begin
         if (state_reg == TMSS_IDLE || test_end) begin
            cal_scan_reg <= cal_pend_reg | i_calibrate;
            cal_pend_reg <= 1'b0;
         end else if (i_calibrate) begin
            cal_pend_reg <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   wire logic rep_dis = (state_reg == TMSS_FIND) && !cur_live;
   wire logic rep_en = (state_reg == TMSS_CONV) && tmr_done;
   wire logic to_dwell = (state_next == TMSS_DWELL);

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_x_drive <= '0;
         o_y_capture <= '0;
         o_convert <= 1'b0;
      end else begin
         // One of 8 X, one of 3 Y
         o_x_drive <= to_dwell ? NUM_X'(1) << key_x : '0;
         o_y_capture <= to_dwell ? NUM_Y'(1) << key_y : '0;
         o_convert <= (state_next == TMSS_CONV);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_self_test <= 1'b0;
         o_scan_done <= 1'b0;
      end else begin
         o_self_test <= (state_reg == TMSS_TEST) && !tmr_done;
         o_scan_done <= test_end;
      end
   end

   // ------------------------------------------------------------
   // Key report
   // ------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_report_valid <= 1'b0;
         o_report_key <= 5'h00;
         o_report_signal <= '0;
         o_report_reference <= '0;
         o_report_low_signal <= 1'b0;
         o_report_calibrating <= 1'b0;
         o_report_cal_failed <= 1'b0;
         o_report_detect <= 1'b0;
      end else begin
         o_report_valid <= rep_dis | rep_en;
         o_report_key <= key_reg;
         o_report_signal <= rep_en ? adc_s2_reg : '0;
         o_report_reference <= rep_en ? adc_s2_reg : '0;
         // Low-signal only if limit above zero
         o_report_low_signal <= rep_dis && (i_lower_signal_limit != 8'h00);
         o_report_calibrating <= cal_scan_reg;
         o_report_cal_failed <= rep_dis;
         o_report_detect <= 1'b0;
      end
   end
endmodule // tmss_scan_seq
`default_nettype wire

// *** tmss_scan_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module tmss_scan_assertions #(
   parameter int NUM_X = 8,
   parameter int NUM_Y = 3,
   parameter int SIG_W = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Watched ports
   input wire logic [NUM_X*NUM_Y*4-1:0] i_normal_detect_integrator_limit,
   input wire logic [7:0] i_lower_signal_limit,
   input wire logic [NUM_X-1:0] o_x_drive,
   input wire logic [NUM_Y-1:0] o_y_capture,
   input wire logic o_convert,
   input wire logic o_report_valid,
   input wire logic [4:0] o_report_key,
   input wire logic [SIG_W-1:0] o_report_signal,
   input wire logic [SIG_W-1:0] o_report_reference,
   input wire logic o_report_low_signal,
   input wire logic o_report_cal_failed,
   input wire logic o_report_detect,
   input wire logic o_scan_done,
   input wire logic o_self_test
);
   // ----------------
   // Helper logic
   // ----------------
   default clocking @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   logic [5:0] dwell_cnt;
   logic [4:0] prev_key_reg;
   logic have_prev_reg;
   wire key_off = i_normal_detect_integrator_limit[o_report_key*4 +: 4] == 4'h0;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dwell_cnt <= 6'h00;
         prev_key_reg <= 5'h00;
         have_prev_reg <= 1'h0;
      end else begin
         dwell_cnt <= (|o_x_drive) ? dwell_cnt + 6'h01 : 6'h00;
         have_prev_reg <= o_scan_done ? 1'h0 : (have_prev_reg | o_report_valid);
         prev_key_reg <= o_report_valid ? o_report_key : prev_key_reg;
      end
   end
   sequence conv_end_s;
      $fell(o_convert);
   endsequence
   // ----------------
   // Assertions
   // ----------------
   one_hot_a: assert property (
      (|o_x_drive) |-> $onehot(o_x_drive) && $onehot(o_y_capture))
      else $error("drive lines not one-hot");
   dwell_len_a: assert property (
      $fell(|o_x_drive) |-> dwell_cnt inside {6'h2e, 6'h2f})
      else $error("dwell window length wrong");
   key_order_a: assert property (
      o_report_valid && have_prev_reg |-> o_report_key > prev_key_reg)
      else $error("key order not ascending");
   scan_start_a: assert property (
      o_report_valid && !have_prev_reg |-> o_report_key == 5'h00)
      else $error("scan not starting at key zero");
   conv_quiet_a: assert property (
      o_convert |-> !(|o_x_drive))
      else $error("drive active during conversion");
   conv_report_a: assert property (
      conv_end_s |-> ##[0:1] o_report_valid && !key_off)
      else $error("no report after conversion");
   off_zero_a: assert property (
      o_report_valid && key_off |-> o_report_signal == '0 && o_report_reference == '0)
      else $error("disabled key values not zero");
   off_flags_a: assert property (
      o_report_valid && key_off |-> o_report_cal_failed && !o_report_detect)
      else $error("disabled key flags wrong");
   low_sig_a: assert property (
      o_report_valid && key_off |->
      o_report_low_signal == ($past(i_lower_signal_limit) != 8'h00))
      else $error("disabled key low signal flag wrong");
   test_quiet_a: assert property (
      o_self_test |-> !(|o_x_drive) && !o_convert && !o_report_valid)
      else $error("scan activity during self-test");
   done_after_a: assert property (
      o_scan_done |-> $past(o_self_test))
      else $error("scan done without self-test");
endmodule // tmss_scan_assertions
bind tmss_scan_seq tmss_scan_assertions #(.NUM_X(NUM_X), .NUM_Y(NUM_Y), .SIG_W(SIG_W)) chk_inst (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_normal_detect_integrator_limit(i_normal_detect_integrator_limit),
   .i_lower_signal_limit(i_lower_signal_limit), .o_x_drive(o_x_drive),
   .o_y_capture(o_y_capture), .o_convert(o_convert), .o_report_valid(o_report_valid),
   .o_report_key(o_report_key), .o_report_signal(o_report_signal),
   .o_report_reference(o_report_reference), .o_report_low_signal(o_report_low_signal),
   .o_report_cal_failed(o_report_cal_failed), .o_report_detect(o_report_detect),
   .o_scan_done(o_scan_done), .o_self_test(o_self_test));
`default_nettype wire

// *** tmss_matrix_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module tmss_matrix_model (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Matrix side
   input wire logic [7:0] i_x_drive,
   input wire logic [2:0] i_y_capture,
   input wire logic i_report_valid,
   output logic [15:0] o_adc_value
);
   // Charge grows by one count per captured pulse, cleared per report
   logic cap_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cap_q <= 1'h0;
         o_adc_value <= 16'h0000;
      end else begin
         cap_q <= |i_y_capture;
         if (i_report_valid) begin
            o_adc_value <= 16'h0000;
         end else if ((|i_y_capture) && !cap_q && (|i_x_drive)) begin
            o_adc_value <= o_adc_value + 16'h0001;
         end
      end
   end
endmodule // tmss_matrix_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct {logic [4:0] k; logic [7:0] b; logic [3:0] l; logic [15:0] s;} tmss_row_t;
   tmss_row_t rows [5] = '{'{5'h00, 8'h03, 4'h2, 16'h0003}, '{5'h01, 8'h05, 4'h0, 16'h0000},
      '{5'h07, 8'h01, 4'h1, 16'h0001}, '{5'h08, 8'h02, 4'hf, 16'h0002},
      '{5'h17, 8'h04, 4'h3, 16'h0004}};
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [191:0] bpc = {24{8'h01}};
   logic [95:0] normal_detect_integrator_limit = '0;
   logic [7:0] lower_signal_limit = 8'h05;
   logic cal = 1'h0;
   logic [15:0] adc, rs, rr;
   logic [7:0] xd;
   logic [2:0] yc;
   logic [4:0] rk;
   logic conv, rv, lo, cf, calf, det, sd, st, off;
   int err_count = 0;
   int n_checks = 0;
   int pcnt = 0;
   int last_pcnt = 0;
   always #4 sys_clk = ~sys_clk;
   tmss_scan_seq #(.SELFTEST_CYC(200)) tmss_scan_seq_inst (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
      .i_burst_pulse_count(bpc), .i_normal_detect_integrator_limit(normal_detect_integrator_limit),
      .i_lower_signal_limit(lower_signal_limit), .i_calibrate(cal), .i_adc_value(adc), .o_x_drive(xd),
      .o_y_capture(yc), .o_convert(conv), .o_report_valid(rv), .o_report_key(rk),
      .o_report_signal(rs), .o_report_reference(rr), .o_report_low_signal(lo),
      .o_report_calibrating(cf), .o_report_cal_failed(calf), .o_report_detect(det),
      .o_scan_done(sd), .o_self_test(st));
   tmss_matrix_model tmss_matrix_model_inst (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
      .i_x_drive(xd), .i_y_capture(yc), .i_report_valid(rv), .o_adc_value(adc));
   // Pulses per scan
   always @(posedge sys_clk) begin
      if (sd) begin
         last_pcnt <= pcnt;
         pcnt <= 0;
      end else if ($rose(|xd)) begin
         pcnt <= pcnt + 1;
      end
   end
   // ----------------
   // Tasks
   // ----------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_ev(input logic [4:0] k, input logic done);
      int n;
      n = 0;
      @(negedge sys_clk);
      while (!(done ? sd === 1'h1 : (rv === 1'h1 && rk === k)) && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      chk({10'h000, sd, rk}, {10'h000, done, done ? rk : k});
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------
   // Tests
   // ----------------
   initial begin
      #400000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      for (int i = 0; i < 5; i++) begin
         bpc[rows[i].k*8 +: 8] = rows[i].b;
         normal_detect_integrator_limit[rows[i].k*4 +: 4] = rows[i].l;
      end
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'h1;
      for (int i = 0; i < 5; i++) begin
         off = rows[i].l == 4'h0;
         wait_ev(rows[i].k, 1'h0);
         chk(rs, rows[i].s);
         chk(rr, rows[i].s);
         chk({13'h0, calf & off, det & off, lo & off}, {13'h0, off, 1'h0, off});
         chk({15'h0000, cf & off}, {15'h0000, off});
      end
      wait_ev(5'h00, 1'h1);
      @(negedge sys_clk);
      chk(last_pcnt[15:0], 16'h000a);
      $display("TEST row scan done");
      wait_ev(5'h01, 1'h0);
      chk({15'h0000, cf}, 16'h0000);
      @(posedge sys_clk);
      cal <= 1'h1;
      lower_signal_limit <= 8'h00;
      @(posedge sys_clk);
      cal <= 1'h0;
      wait_ev(5'h01, 1'h0);
      chk({14'h0000, cf, lo}, 16'h0002);
      $display("TEST calibrate done");
      @(posedge sys_clk);
      rst_n <= 1'h0;
      repeat (2) @(negedge sys_clk);
      chk({1'h0, xd, yc, conv, rv, st, sd}, 16'h0000);
      @(posedge sys_clk);
      rst_n <= 1'h1;
      wait_ev(5'h00, 1'h0);
      wait_ev(5'h01, 1'h0);
      chk({15'h0000, cf}, 16'h0001);
      $display("TEST mid reset done");
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
